/* File: src/roll_instrument.sv */
// Instrument end: sync decoder, sky map stepping, modes, commands, packet framer
//
// Overview of operation
// - One sync pulse marks each 0.1 degree
// - Double pulse is the nadir marker
// - Triple pulse is the Sun marker
// - Protect heads while Sun near field
// - Advance sky map position per roll pulse
// - Modes 2 and 3 send buffered data
// - Packet transmission starts at nadir marker
// - Sky maps 0x03/0x05/0x0E, 62440 bytes
// - Histograms 0x12/0x14/0x17, 2088 bytes
// - Event counts 0x22/0x24/0x27, 7240 bytes
// - Housekeeping 0x28, 38444 bytes
// - Status 0x30, 2088 bytes
// - Secondary maps 0x33/0x35/0x3E, 62440 bytes
// - Calibration identifiers 0x43/0x45/0x4E reserved
// - Memory dump uses identifier 0x00
// - Spins 0-2: map, events, histogram, status
// - Spin 3 housekeeping+status; spin 4 status
// - Sequence repeats every five spins
// - Serial 38400 bps, 8 bits, no parity
// - Orbit volume bounded by fixed sequence
// - Instrument controlled only by link commands
// - Safe command steps mode down by one
`timescale 1ns/1ps
`default_nettype none

// Byte FIFO; ready and valid are registered so the source sees back-pressure
module byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic in_ready_reg;
	logic out_valid_reg;
	wire push = in_valid & in_ready_reg;
	wire pop = out_valid_reg & out_ready;

	// Depth must be a power of two so the pointers wrap naturally
	assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign in_ready = in_ready_reg;
	assign out_valid = out_valid_reg;
	assign out_data = mem[rptr_reg];

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_reg] <= in_data;
		end
	end

	// Pointers and flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
			in_ready_reg <= 1'b0;
			out_valid_reg <= 1'b0;
		end else begin
			wptr_reg <= wptr_reg + AW'(push);
			rptr_reg <= rptr_reg + AW'(pop);
			count_reg <= count_next;
			in_ready_reg <= (count_next != (AW + 1)'(DEPTH));
			out_valid_reg <= (count_next != '0);
		end
	end
endmodule : byte_fifo

// Serial transmitter: start bit, eight data bits LSB first, stop bit
module serial_tx (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] data,
	input wire logic valid,
	output logic ready,
	output logic line
);
	import roll_tlm_pkg::*;
	logic busy_reg;
	logic ready_reg;
	logic line_reg;
	logic [8:0] shift_reg;
	logic [3:0] bits_reg;
	logic [11:0] cnt_reg;
	wire bit_end = (cnt_reg == 12'h000);

	assign ready = ready_reg;
	assign line = line_reg;

	// Bit timing is the integer divide of the clock, within 0.02 percent
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_reg <= 1'b0;
			ready_reg <= 1'b1;
			line_reg <= 1'b1;
			shift_reg <= '0;
			bits_reg <= '0;
			cnt_reg <= '0;
		end else if (!busy_reg) begin
			if (valid) begin
				busy_reg <= 1'b1;
				ready_reg <= 1'b0;
				line_reg <= 1'b0;
				shift_reg <= {1'b1, data};
				bits_reg <= 4'(DATA_BITS + 1);
				cnt_reg <= 12'(BIT_CYC - 1);
			end
		end else if (bit_end) begin
			cnt_reg <= 12'(BIT_CYC - 1);
			if (bits_reg == 4'h0) begin
				busy_reg <= 1'b0;
				ready_reg <= 1'b1;
			end else begin
				line_reg <= shift_reg[0];
				shift_reg <= {1'b1, shift_reg[8:1]};
				bits_reg <= bits_reg - 4'h1;
			end
		end else begin
			cnt_reg <= cnt_reg - 12'h001;
		end
	end
endmodule : serial_tx

// Serial receiver; a broken stop bit raises err instead of valid
module serial_rx (
	input wire logic clk,
	input wire logic rstn,
	input wire logic line,
	output logic [7:0] data,
	output logic valid,
	output logic err
);
	import roll_tlm_pkg::*;
	logic busy_reg;
	logic [3:0] bits_reg;
	logic [11:0] cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] data_reg;
	logic valid_reg;
	logic err_reg;

	assign data = data_reg;
	assign valid = valid_reg;
	assign err = err_reg;

	// Sample mid-bit; a start bit that is gone at mid-bit is a glitch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_reg <= 1'b0;
			bits_reg <= '0;
			cnt_reg <= '0;
			shift_reg <= '0;
			data_reg <= '0;
			valid_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			valid_reg <= 1'b0;
			err_reg <= 1'b0;
			if (!busy_reg) begin
				if (!line) begin
					busy_reg <= 1'b1;
					bits_reg <= 4'h0;
					cnt_reg <= 12'(HALF_BIT_CYC - 1);
				end
			end else if (cnt_reg != 12'h000) begin
				cnt_reg <= cnt_reg - 12'h001;
			end else begin
				cnt_reg <= 12'(BIT_CYC - 1);
				bits_reg <= bits_reg + 4'h1;
				if (bits_reg == 4'h0 && line) begin
					busy_reg <= 1'b0;
				end else if (bits_reg == 4'(DATA_BITS + 1)) begin
					busy_reg <= 1'b0;
					data_reg <= shift_reg;
					valid_reg <= line;
					err_reg <= ~line;
				end else if (bits_reg != 4'h0) begin
					shift_reg <= {line, shift_reg[7:1]};
				end
			end
		end
	end
endmodule : serial_rx

module roll_instrument #(
	parameter int unsigned GAP_CYC = roll_tlm_pkg::BURST_GAP_CYC
) (
	input wire logic CLK,
	input wire logic RSTN,
	roll_link_if.instr LINK,
	input wire logic [roll_tlm_pkg::FIFO_WIDTH-1:0] DATA_IN,
	input wire logic DATA_VALID,
	output logic DATA_READY,
	output logic [1:0] MODE,
	output logic [11:0] MAP_POS,
	output logic MAP_STEP,
	output logic NADIR_SEEN,
	output logic SUN_SEEN,
	output logic SUN_PROTECT,
	output logic [2:0] SPIN,
	output logic PKT_ACTIVE,
	output logic [7:0] PKT_APID
);
	import roll_tlm_pkg::*;
	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_HDR, ST_BODY} frame_state_e;

	logic sync_d_reg;
	logic [1:0] pulses_reg;
	logic [15:0] gap_reg;
	logic step_reg, nadir_reg, sun_reg;
	logic [11:0] pos_reg, sun_pos_reg;
	logic sun_known_reg, protect_reg;
	logic [1:0] mode_reg;
	logic sec_reg, dump_pend_reg;
	logic [2:0] spin_reg, list_spin_reg;
	logic [1:0] idx_reg;
	logic dump_run_reg;
	frame_state_e state_reg;
	logic [7:0] apid_reg;
	logic [15:0] left_reg;
	logic active_reg;
	logic [7:0] cmd_byte;
	logic cmd_valid;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic tx_ready;
	logic tlm_line;

	// Burst decode: pulses counted until no new rising edge follows the last one within the gap timeout
	wire sync_rise = LINK.sync_line & ~sync_d_reg;
	wire burst_end = (gap_reg == 16'h0001);
	wire [1:0] pulses_now = pulses_reg;
	wire [11:0] pos_inc = (pos_reg == STEPS_PER_SPIN - 12'h001) ? 12'h000 : pos_reg + 12'h001;
	wire [11:0] sun_diff = (pos_reg >= sun_pos_reg) ? pos_reg - sun_pos_reg
		: pos_reg + STEPS_PER_SPIN - sun_pos_reg;
	wire near_sun = sun_known_reg &&
		(sun_diff <= SUN_GUARD_STEPS || sun_diff >= STEPS_PER_SPIN - SUN_GUARD_STEPS);
	wire [2:0] spin_inc = (spin_reg == SPINS_PER_CYCLE - 3'h1) ? 3'h0 : spin_reg + 3'h1;
	wire science_mode = (mode_reg == MODE_2) || (mode_reg == MODE_3);
	wire pkt_kind_e next_kind = dump_run_reg ? PK_DUMP : kind_at(list_spin_reg, idx_reg);
	wire [1:0] head = list_spin_reg[1:0];
	wire tx_valid = (state_reg == ST_HDR) || (state_reg == ST_BODY && fifo_valid);
	wire [7:0] tx_data = (state_reg == ST_HDR) ? apid_reg : fifo_data;
	wire fifo_take = (state_reg == ST_BODY) && tx_ready;
	wire tx_fire = tx_valid && tx_ready;

	byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CLK), .rstn(RSTN), .in_data(DATA_IN), .in_valid(DATA_VALID), .in_ready(DATA_READY),
		.out_data(fifo_data), .out_valid(fifo_valid), .out_ready(fifo_take)
	);

	serial_tx u_tx (
		.clk(CLK), .rstn(RSTN), .data(tx_data), .valid(tx_valid), .ready(tx_ready),
		.line(tlm_line)
	);

	serial_rx u_rx (
		.clk(CLK), .rstn(RSTN), .line(LINK.cmd_line), .data(cmd_byte), .valid(cmd_valid),
		.err()
	);

	assign LINK.tlm_line = tlm_line;
	assign MODE = mode_reg;
	assign MAP_POS = pos_reg;
	assign MAP_STEP = step_reg;
	assign NADIR_SEEN = nadir_reg;
	assign SUN_SEEN = sun_reg;
	assign SUN_PROTECT = protect_reg;
	assign SPIN = spin_reg;
	assign PKT_ACTIVE = active_reg;
	assign PKT_APID = apid_reg;

	// Sync burst classifier; a fourth pulse saturates and reads as a Sun marker
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync_d_reg <= 1'b0;
			pulses_reg <= '0;
			gap_reg <= '0;
			step_reg <= 1'b0;
			nadir_reg <= 1'b0;
			sun_reg <= 1'b0;
		end else begin
			sync_d_reg <= LINK.sync_line;
			step_reg <= burst_end && pulses_now == 2'h1;
			nadir_reg <= burst_end && pulses_now == 2'h2;
			sun_reg <= burst_end && pulses_now == 2'h3;
			if (sync_rise) begin
				gap_reg <= 16'(GAP_CYC);
				pulses_reg <= (pulses_reg == 2'h3) ? 2'h3 : pulses_reg + 2'h1;
			end else if (gap_reg != 16'h0000) begin
				gap_reg <= gap_reg - 16'h0001;
				if (burst_end) begin
					pulses_reg <= 2'h0;
				end
			end
		end
	end

	// Map position: steps on each roll pulse, zeroed at nadir
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pos_reg <= '0;
			sun_pos_reg <= '0;
			sun_known_reg <= 1'b0;
			protect_reg <= 1'b0;
		end else begin
			if (nadir_reg) begin
				pos_reg <= 12'h000;
			end else if (step_reg) begin
				pos_reg <= pos_inc;
			end
			if (sun_reg) begin
				sun_pos_reg <= pos_reg;
				sun_known_reg <= 1'b1;
			end
			protect_reg <= near_sun || sun_reg;
		end
	end

	// Command decode; unknown bytes are ignored
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_reg <= MODE_1;
			sec_reg <= 1'b0;
			dump_pend_reg <= 1'b0;
		end else begin
			if (cmd_valid) begin
				case (cmd_byte)
					CMD_SET_MODE1: mode_reg <= MODE_1;
					CMD_SET_MODE2: mode_reg <= MODE_2;
					CMD_SET_MODE3: mode_reg <= MODE_3;
					CMD_MAP_PRIMARY: sec_reg <= 1'b0;
					CMD_MAP_SECONDARY: sec_reg <= 1'b1;
					CMD_SAFE_STEP: mode_reg <= (mode_reg == MODE_1) ? MODE_1 : mode_reg - 2'h1;
					default: mode_reg <= mode_reg;
				endcase
			end
			// A new request in the cycle the dump starts is kept
			if (cmd_valid && cmd_byte == CMD_DUMP) begin
				dump_pend_reg <= 1'b1;
			end else if (state_reg == ST_IDLE && dump_pend_reg && !nadir_reg) begin
				dump_pend_reg <= 1'b0;
			end
		end
	end

	// Spin counter; the packet list follows it round the five-spin cycle
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			spin_reg <= '0;
		end else if (nadir_reg) begin
			spin_reg <= spin_inc;
		end
	end

	// Packet framer; a nadir marker while busy does not restart the list
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= ST_IDLE;
			list_spin_reg <= '0;
			idx_reg <= '0;
			dump_run_reg <= 1'b0;
			apid_reg <= '0;
			left_reg <= '0;
			active_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					idx_reg <= 2'h0;
					if (nadir_reg && science_mode) begin
						list_spin_reg <= spin_reg;
						dump_run_reg <= 1'b0;
						state_reg <= ST_LOAD;
					end else if (dump_pend_reg && !nadir_reg) begin
						dump_run_reg <= 1'b1;
						state_reg <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					// Spin list and identifiers
					// Same mapping covers the rest
					// Calibration identifiers are never selected
					if (next_kind == PK_NONE || (!dump_run_reg && !science_mode)) begin
						state_reg <= ST_IDLE;
					end else begin
						apid_reg <= apid_of(next_kind, head, sec_reg);
						left_reg <= len_of(next_kind) - 16'h0001;
						state_reg <= ST_HDR;
						active_reg <= 1'b1;
					end
				end
				ST_HDR: begin
					if (tx_fire) begin
						state_reg <= ST_BODY;
					end
				end
				ST_BODY: begin
					if (tx_fire) begin
						left_reg <= left_reg - 16'h0001;
						if (left_reg == 16'h0001) begin
							// Fixed list keeps each orbit within its volume
							// Status closes a four-packet spin; stop before the index wraps
							state_reg <= (dump_run_reg || idx_reg == 2'h3) ? ST_IDLE : ST_LOAD;
							idx_reg <= idx_reg + 2'h1;
							active_reg <= 1'b0;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					active_reg <= 1'b0;
				end
			endcase
		end
	end
endmodule : roll_instrument
`default_nettype wire

/* File: src/roll_tlm_pkg.sv */
// Shared constants, packet tables and helpers for the roll-sync telemetry link
package roll_tlm_pkg;
	// Clock and serial timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_NS = 10;
	localparam int unsigned BAUD_BPS = 38_400;
	localparam int unsigned BIT_CYC = CLK_HZ / BAUD_BPS;
	localparam int unsigned HALF_BIT_CYC = BIT_CYC / 2;
	localparam int unsigned DATA_BITS = 8;
	// Sync pulse shape and gap timeout
	localparam int unsigned PULSE_HIGH_NS = 1000;
	localparam int unsigned PULSE_LOW_NS = 1000;
	localparam int unsigned BURST_GAP_NS = 5000;
	localparam int unsigned PULSE_HIGH_CYC = (PULSE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PULSE_LOW_CYC = (PULSE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BURST_GAP_CYC = BURST_GAP_NS / CLK_NS;
	// Roll geometry: one step is 0.1 degree
	localparam real ROLL_STEP_DEG = 0.1;
	localparam logic [11:0] STEPS_PER_SPIN = 12'h0E10;
	localparam logic [11:0] SUN_GUARD_STEPS = 12'h0064;
	localparam logic [2:0] SPINS_PER_CYCLE = 3'h5;
	localparam int unsigned CYCLE_MINUTES = 10;
	// Operating modes
	localparam logic [1:0] MODE_1 = 2'h1;
	localparam logic [1:0] MODE_2 = 2'h2;
	localparam logic [1:0] MODE_3 = 2'h3;
	// Command bytes
	localparam logic [7:0] CMD_SET_MODE1 = 8'h01;
	localparam logic [7:0] CMD_SET_MODE2 = 8'h02;
	localparam logic [7:0] CMD_SET_MODE3 = 8'h03;
	localparam logic [7:0] CMD_DUMP = 8'h04;
	localparam logic [7:0] CMD_MAP_PRIMARY = 8'h05;
	localparam logic [7:0] CMD_MAP_SECONDARY = 8'h06;
	localparam logic [7:0] CMD_SAFE_STEP = 8'h0F;
	// Application identifiers
	localparam logic [7:0] APID_SKY0 = 8'h03;
	localparam logic [7:0] APID_SKY1 = 8'h05;
	localparam logic [7:0] APID_SKY2 = 8'h0E;
	localparam logic [7:0] APID_HIST0 = 8'h12;
	localparam logic [7:0] APID_HIST1 = 8'h14;
	localparam logic [7:0] APID_HIST2 = 8'h17;
	localparam logic [7:0] APID_EVT0 = 8'h22;
	localparam logic [7:0] APID_EVT1 = 8'h24;
	localparam logic [7:0] APID_EVT2 = 8'h27;
	localparam logic [7:0] APID_HK = 8'h28;
	localparam logic [7:0] APID_STATUS = 8'h30;
	localparam logic [7:0] APID_SEC0 = 8'h33;
	localparam logic [7:0] APID_SEC1 = 8'h35;
	localparam logic [7:0] APID_SEC2 = 8'h3E;
	localparam logic [7:0] APID_CAL0 = 8'h43;
	localparam logic [7:0] APID_CAL1 = 8'h45;
	localparam logic [7:0] APID_CAL2 = 8'h4E;
	localparam logic [7:0] APID_DUMP = 8'h00;
	// Packet lengths in bytes, identifier byte included
	localparam logic [15:0] LEN_MAP = 16'hF3E8;
	localparam logic [15:0] LEN_HIST = 16'h0828;
	localparam logic [15:0] LEN_EVT = 16'h1C48;
	localparam logic [15:0] LEN_HK = 16'h962C;
	localparam logic [15:0] LEN_STATUS = 16'h0828;
	localparam logic [15:0] LEN_DUMP = 16'h0100;
	// Buffer shape
	localparam int unsigned FIFO_WIDTH = 8;
	localparam int unsigned FIFO_DEPTH = 4;

	typedef enum logic [2:0] {PK_NONE, PK_MAP, PK_EVT, PK_HIST, PK_HK, PK_STATUS, PK_DUMP}
		pkt_kind_e;

	// Packet at position idx of the list sent in a given spin
	function automatic pkt_kind_e kind_at(input logic [2:0] spin, input logic [1:0] idx);
		pkt_kind_e k;
		k = PK_NONE;
		if (spin < 3'h3) begin
			case (idx)
				2'h0: k = PK_MAP;
				2'h1: k = PK_EVT;
				2'h2: k = PK_HIST;
				default: k = PK_STATUS;
			endcase
		end else if (spin == 3'h3) begin
			k = (idx == 2'h0) ? PK_HK : ((idx == 2'h1) ? PK_STATUS : PK_NONE);
		end else if (idx == 2'h0) begin
			k = PK_STATUS;
		end
		return k;
	endfunction : kind_at

	function automatic logic [7:0] apid_of(input pkt_kind_e k, input logic [1:0] head,
			input logic sec);
		logic [7:0] a;
		a = APID_DUMP;
		case (k)
			PK_MAP: a = sec ? ((head == 2'h0) ? APID_SEC0 : (head == 2'h1) ? APID_SEC1 : APID_SEC2)
				: ((head == 2'h0) ? APID_SKY0 : (head == 2'h1) ? APID_SKY1 : APID_SKY2);
			PK_EVT: a = (head == 2'h0) ? APID_EVT0 : (head == 2'h1) ? APID_EVT1 : APID_EVT2;
			PK_HIST: a = (head == 2'h0) ? APID_HIST0 : (head == 2'h1) ? APID_HIST1 : APID_HIST2;
			PK_HK: a = APID_HK;
			PK_STATUS: a = APID_STATUS;
			default: a = APID_DUMP;
		endcase
		return a;
	endfunction : apid_of

	function automatic logic [15:0] len_of(input pkt_kind_e k);
		logic [15:0] n;
		n = LEN_DUMP;
		case (k)
			PK_MAP: n = LEN_MAP;
			PK_EVT: n = LEN_EVT;
			PK_HIST: n = LEN_HIST;
			PK_HK: n = LEN_HK;
			PK_STATUS: n = LEN_STATUS;
			default: n = LEN_DUMP;
		endcase
		return n;
	endfunction : len_of
endpackage : roll_tlm_pkg

/* File: src/roll_link_if.sv */
// Link between data processor and instrument: sync, command and telemetry lines
`timescale 1ns/1ps
`default_nettype none
interface roll_link_if;
	logic sync_line;
	logic cmd_line;
	logic tlm_line;
	modport instr (input sync_line, input cmd_line, output tlm_line);
	modport proc (output sync_line, output cmd_line, input tlm_line);
endinterface : roll_link_if
`default_nettype wire

/* File: src/roll_processor.sv */
// Data processor end: sync pulse bursts, command sender, telemetry receiver
`timescale 1ns/1ps
`default_nettype none
module roll_processor (
	input wire logic CLK,
	input wire logic RSTN,
	roll_link_if.proc LINK,
	input wire logic ROLL_STEP,
	input wire logic NADIR_MARK,
	input wire logic SUN_MARK,
	output logic SYNC_BUSY,
	input wire logic [7:0] CMD_DATA,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	output logic [7:0] TLM_DATA,
	output logic TLM_VALID,
	output logic TLM_ERR
);
	import roll_tlm_pkg::*;
	typedef enum logic [1:0] {SY_IDLE, SY_HIGH, SY_LOW} sync_state_e;

	sync_state_e sy_state_reg;
	logic [1:0] left_reg;
	logic [11:0] cnt_reg;
	logic sync_reg;
	logic cmd_line;
	logic tx_ready;
	logic burst_busy_reg;
	wire [1:0] burst_len = SUN_MARK ? 2'h3 : (NADIR_MARK ? 2'h2 : 2'h1);
	wire burst_req = ROLL_STEP || NADIR_MARK || SUN_MARK;

	serial_tx u_cmd_tx (
		.clk(CLK), .rstn(RSTN), .data(CMD_DATA), .valid(CMD_VALID), .ready(tx_ready),
		.line(cmd_line)
	);

	serial_rx u_tlm_rx (
		.clk(CLK), .rstn(RSTN), .line(LINK.tlm_line), .data(TLM_DATA), .valid(TLM_VALID),
		.err(TLM_ERR)
	);

	assign LINK.cmd_line = cmd_line;
	assign LINK.sync_line = sync_reg;
	assign CMD_READY = tx_ready;
	assign SYNC_BUSY = burst_busy_reg;

	// Burst generator; requests while a burst runs are dropped
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sy_state_reg <= SY_IDLE;
			left_reg <= '0;
			cnt_reg <= '0;
			sync_reg <= 1'b0;
			burst_busy_reg <= 1'b0;
		end else begin
			case (sy_state_reg)
				SY_IDLE: begin
					if (burst_req) begin
						sync_reg <= 1'b1;
						burst_busy_reg <= 1'b1;
						left_reg <= burst_len - 2'h1;
						cnt_reg <= 12'(PULSE_HIGH_CYC - 1);
						sy_state_reg <= SY_HIGH;
					end
				end
				SY_HIGH: begin
					if (cnt_reg == 12'h000) begin
						sync_reg <= 1'b0;
						cnt_reg <= 12'(PULSE_LOW_CYC - 1);
						sy_state_reg <= SY_LOW;
					end else begin
						cnt_reg <= cnt_reg - 12'h001;
					end
				end
				SY_LOW: begin
					// Final low time spans the instrument gap timeout before reuse
					// Left count 3 marks the quiet time; no burst reaches it
					if (cnt_reg != 12'h000) begin
						cnt_reg <= cnt_reg - 12'h001;
					end else if (left_reg == 2'h3) begin
						left_reg <= 2'h0;
						burst_busy_reg <= 1'b0;
						sy_state_reg <= SY_IDLE;
					end else if (left_reg != 2'h0) begin
						sync_reg <= 1'b1;
						left_reg <= left_reg - 2'h1;
						cnt_reg <= 12'(PULSE_HIGH_CYC - 1);
						sy_state_reg <= SY_HIGH;
					end else begin
						left_reg <= 2'h3;
						cnt_reg <= 12'(BURST_GAP_CYC);
					end
				end
				default: begin
					sy_state_reg <= SY_IDLE;
					burst_busy_reg <= 1'b0;
				end
			endcase
		end
	end
endmodule : roll_processor
`default_nettype wire

/* File: verif/roll_sync_telemetry_sequencer_properties.sv */
// Wire-level checks on the sync, command and telemetry lines
`timescale 1ns/1ps
`default_nettype none
module roll_sync_telemetry_sequencer_properties (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic sync_line,
	input wire logic cmd_line,
	input wire logic tlm_line
);
	import roll_tlm_pkg::*;
	localparam int unsigned LOW_MAX = (DATA_BITS + 1) * BIT_CYC;
	logic sp_reg, cp_reg, tp_reg;
	logic [15:0] srun_reg, crun_reg, trun_reg;
	logic [15:0] srun_next, crun_next, trun_next;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Cycles since each line last changed; saturates so long idle time cannot wrap
	assign srun_next = (sync_line != sp_reg) ? 16'h0000 : srun_reg + {15'h0000, srun_reg != 16'hFFFF};
	assign crun_next = (cmd_line != cp_reg) ? 16'h0000 : crun_reg + {15'h0000, crun_reg != 16'hFFFF};
	assign trun_next = (tlm_line != tp_reg) ? 16'h0000 : trun_reg + {15'h0000, trun_reg != 16'hFFFF};
	// Previous level and run length per line
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			{sp_reg, cp_reg, tp_reg} <= 3'h3;
			// Idle out of reset counts as a long run, so the first pulse is not flagged
			{srun_reg, crun_reg, trun_reg} <= 48'hFFFF_FFFF_FFFF;
		end else begin
			{sp_reg, cp_reg, tp_reg} <= {sync_line, cmd_line, tlm_line};
			{srun_reg, crun_reg, trun_reg} <= {srun_next, crun_next, trun_next};
		end
	end
	a_links_idle: assert property ($rose(RSTN) |-> cmd_line && tlm_line && !sync_line)
		else $error("line not idle after reset");
	a_sync_high_width: assert property ($rose(sync_line) |-> ##99 sync_line ##1 !sync_line)
		else $error("sync pulse width wrong");
	a_sync_gap_low: assert property ($fell(sync_line) |-> ##99 !sync_line)
		else $error("sync gap too short");
	a_sync_spacing: assert property ($rose(sync_line) |-> srun_reg >= 16'h0063)
		else $error("sync pulses too close");
	a_cmd_bit_time: assert property (cmd_line && !cp_reg |-> (crun_reg + 16'h0001) % BIT_CYC == 0)
		else $error("command bit time wrong");
	a_cmd_low_bound: assert property (!cmd_line && !cp_reg |-> crun_reg < LOW_MAX)
		else $error("command line low past stop bit");
	a_tlm_bit_time: assert property (tlm_line && !tp_reg |-> (trun_reg + 16'h0001) % BIT_CYC == 0)
		else $error("telemetry bit time wrong");
	a_tlm_low_bound: assert property (!tlm_line && !tp_reg |-> trun_reg < LOW_MAX)
		else $error("telemetry line low past stop bit");
	// Main traffic seen
	cover property ($rose(sync_line) ##100 !sync_line ##100 sync_line);
	cover property ($fell(cmd_line));
	cover property ($fell(tlm_line));
endmodule : roll_sync_telemetry_sequencer_properties
`default_nettype wire

/* File: verif/roll_sync_telemetry_sequencer_tb_top.sv */
// Self-checking bench: processor and instrument ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module roll_sync_telemetry_sequencer_tb_top;
	import roll_tlm_pkg::*;
	logic clk, rstn, step, nadir, sun, cmd_valid, data_valid, pkt_prev;
	logic [7:0] cmd_data, data_in, pkt_apid, tlm_data;
	logic data_ready, map_step, nadir_seen, sun_seen, sun_protect, pkt_active;
	logic sync_busy, cmd_ready, tlm_valid, tlm_err;
	logic [1:0] mode;
	logic [11:0] map_pos;
	logic [2:0] spin;
	int err_count, tests_run, cyc, n_step, n_nadir, n_sun, n_pkt, n_acc, n_terr;
	logic [7:0] rx_q[$];
	// Burst kind, then expected step, nadir and sun counts and map position
	int rows [4][5] = '{'{1, 1, 0, 0, 1}, '{1, 2, 0, 0, 2}, '{2, 2, 1, 0, 0}, '{3, 2, 1, 1, 0}};
	roll_link_if link();
	roll_instrument #(.GAP_CYC(BURST_GAP_CYC)) i_roll_instrument (.CLK(clk), .RSTN(rstn),
		.LINK(link), .DATA_IN(data_in), .DATA_VALID(data_valid), .DATA_READY(data_ready),
		.MODE(mode), .MAP_POS(map_pos), .MAP_STEP(map_step), .NADIR_SEEN(nadir_seen),
		.SUN_SEEN(sun_seen), .SUN_PROTECT(sun_protect), .SPIN(spin), .PKT_ACTIVE(pkt_active),
		.PKT_APID(pkt_apid));
	roll_processor i_roll_processor (.CLK(clk), .RSTN(rstn), .LINK(link), .ROLL_STEP(step),
		.NADIR_MARK(nadir), .SUN_MARK(sun), .SYNC_BUSY(sync_busy), .CMD_DATA(cmd_data),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .TLM_DATA(tlm_data),
		.TLM_VALID(tlm_valid), .TLM_ERR(tlm_err));
	roll_sync_telemetry_sequencer_properties i_props (.CLK(clk), .RSTN(rstn),
		.sync_line(link.sync_line), .cmd_line(link.cmd_line), .tlm_line(link.tlm_line));
	// Clock at 100 MHz
	always #5 clk = ~clk;
	// Count decode pulses, packet starts and received bytes; watchdog cuts a hang short
	always @(posedge clk) begin
		cyc++;
		n_step += map_step;
		n_nadir += nadir_seen;
		n_sun += sun_seen;
		n_terr += tlm_err;
		if (pkt_active && !pkt_prev) n_pkt++;
		pkt_prev = pkt_active;
		if (tlm_valid) rx_q.push_back(tlm_data);
		if (cyc == 95000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One burst request; idle again only after the quiet time
	task automatic sync_req(input int k);
		@(negedge clk);
		{step, nadir, sun} = {k == 1, k == 2, k == 3};
		@(negedge clk);
		{step, nadir, sun} = 3'h0;
		while (sync_busy) @(negedge clk);
		repeat (10) @(negedge clk);
	endtask : sync_req
	task automatic send_cmd(input logic [7:0] b);
		@(negedge clk);
		while (!cmd_ready) @(negedge clk);
		cmd_data = b;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask : send_cmd
	task automatic wait_rx(input int n);
		while (rx_q.size() < n) @(negedge clk);
	endtask : wait_rx
	task automatic tally_and_finish();
		if (err_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		{clk, rstn, step, nadir, sun, cmd_valid, data_valid, pkt_prev} = 8'h00;
		{cmd_data, data_in} = 16'h0000;
		repeat (2) @(negedge clk);
		chk({data_ready, mode, spin, map_pos}, {1'b0, MODE_1, 3'h0, 12'h000});
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		foreach (rows[i]) begin
			sync_req(rows[i][0]);
			chk({n_step[3:0], n_nadir[3:0], n_sun[3:0], map_pos}, {rows[i][1][3:0],
				rows[i][2][3:0], rows[i][3][3:0], rows[i][4][11:0]});
		end
		chk({sun_protect, spin, n_pkt[3:0]}, {1'b1, 3'h1, 4'h0});
		// Fill the buffer while the framer is idle; it must refuse after four
		for (int j = 0; j < 8; j++) begin
			@(negedge clk);
			data_in = 8'hA0 + 8'(j);
			data_valid = 1'b1;
			// Ready is registered: its level now is what the next rising edge sees
			if (data_ready) n_acc++;
		end
		@(negedge clk);
		data_valid = 1'b0;
		chk(n_acc, FIFO_DEPTH);
		send_cmd(CMD_SET_MODE3);
		while (mode !== MODE_3) @(negedge clk);
		sync_req(2);
		chk({pkt_active, pkt_apid}, {1'b1, APID_SKY1});
		// Safe steps overlap the outgoing telemetry bytes
		send_cmd(CMD_SAFE_STEP);
		wait_rx(1);
		// Safe step byte lands before its sender goes idle again
		while (!cmd_ready) @(negedge clk);
		chk({mode, rx_q[0]}, {MODE_2, APID_SKY1});
		send_cmd(CMD_SAFE_STEP);
		wait_rx(2);
		while (!cmd_ready) @(negedge clk);
		chk({mode, rx_q[1], data_ready}, {MODE_1, 8'hA0, 1'b1});
		chk(n_terr, 32'h0000_0000);
		tally_and_finish();
	end
endmodule : roll_sync_telemetry_sequencer_tb_top
`default_nettype wire
